/* rtl/rmcb_defs.vh */
// offsets, bit positions, access masks and reset values of the ram-mapped control bit bank
`ifndef RMCB_DEFS_VH
`define RMCB_DEFS_VH

// data address space
`define RMCB_ADDR_W        11
`define RMCB_RAM_DEPTH     1876
`define RMCB_RAM_BASE      11'h0040
`define RMCB_RAM_END       11'h0794
`define RMCB_SFR_LO_FIRST  11'h0004
`define RMCB_SFR_LO_LAST   11'h001F
`define RMCB_SFR_HI_FIRST  11'h0024
`define RMCB_SFR_HI_LAST   11'h003F
`define RMCB_REG_AREA_LAST 11'h003F
`define RMCB_DISP_CTRL     11'h001B

// control nibbles: 0x000-0x003 and 0x020-0x023
`define RMCB_INTR_CTRL_EXT0_ENABLE   11'h0000
`define RMCB_INTR_CTRL_EXT1_TIMER_A  11'h0001
`define RMCB_INTR_CTRL_TIMER_B_C     11'h0002
`define RMCB_INTR_CTRL_TIMER_D_ADC   11'h0003
`define RMCB_FLAG_POWER_WATCHDOG_ADC 11'h0020
`define RMCB_FLAG_CAPTURE_RAM_ENABLE 11'h0021
`define RMCB_INTR_CTRL_EXT2_EXT3     11'h0022
`define RMCB_INTR_CTRL_EXT4_SERIAL   11'h0023

// flat bit positions in the 32-bit control vector (nibble * 4 + bit)
`define RMCB_POS_GLOBAL_IRQ_ENABLE 0
`define RMCB_POS_SP_RESET          1
`define RMCB_POS_LOW_SPEED_ON      16
`define RMCB_POS_WATCHDOG_ON       17
`define RMCB_POS_ADC_START         18
`define RMCB_POS_DIRECT_XFER_ON    19
`define RMCB_POS_CAPTURE_STATUS    20
`define RMCB_POS_CAPTURE_ERROR     21
`define RMCB_POS_RAM_ENABLE        23

// per-bit permissions and reset value
`define RMCB_CTL_RESET  32'hAA00_AAA8
`define RMCB_SET_OK     32'hFF0F_FFFD
`define RMCB_CLR_OK     32'hFFB9_FFFF
`define RMCB_TST_OK     32'hFFBD_FFFD

// special function register access classes, one bit per address
`define RMCB_SFR_RO_MASK 64'h0000_0000_0180_0000
`define RMCB_SFR_WO_MASK 64'h0000_0000_0000_0100

// operation codes from the core
`define RMCB_OP_READ  3'h0
`define RMCB_OP_WRITE 3'h1
`define RMCB_OP_SET   3'h2
`define RMCB_OP_CLEAR 3'h3
`define RMCB_OP_TEST  3'h4

// interrupt sources and rom regions
`define RMCB_NUM_SRC       11
`define RMCB_EXT_ACT_LOW   5'h03
`define RMCB_VECTOR_LAST   14'h000F
`define RMCB_RESET_VECTOR  14'h0000
`define RMCB_ZPAGE_MASK    14'h003F
`define RMCB_PATTERN_MASK  14'h0FFF
`define RMCB_ROM_CAL       2'h1
`define RMCB_ROM_PATTERN   2'h2

`endif

/* rtl/rmcb_bank.v */
// decode and bit storage for the ram-mapped register region, data ram and rom region addressing
`timescale 1ns/100ps
`include "rmcb_defs.vh"

// Summary of operation
// RULE_01: reset and interrupts vector into words 0x0-0xF
// RULE_02: short call lands only in 0x0000-0x003F
// RULE_03: pattern fetch addresses rom 0x0000-0x0FFF
// RULE_04: 1876 nibbles ram, registers at 0x000-0x03F
// RULE_05: 0x000-0x003 reached only by bit instructions
// RULE_06: sfr window decoded with w, r, rw classes
// RULE_07: only display control takes bit set/clear
// RULE_08: 0x020-0x023 reached only by bit instructions
// RULE_09: every source has request flag and mask
// RULE_10: 0x000 holds enable, sp reset, ext0 flag, mask
// RULE_11: 0x020 and 0x021 flag bit layout
// RULE_12: stop clear input returns stop to active
// RULE_13: watchdog flag cleared by reset and stop clear
// RULE_14: testing inhibited bits gives undefined status
// RULE_15: unused bits read zero, ignore writes
// RULE_16: reset leaves every interrupt masked and disabled
module rmcb_bank (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // core data access
    input  wire        op_valid,
    input  wire [2:0]  op_kind,
    input  wire [10:0] op_addr,
    input  wire [1:0]  op_bit,
    input  wire [3:0]  op_wdata,
    output reg  [3:0]  rd_data_q,
    output reg         rd_valid_q,
    output reg         status_flag_q,
    // read-only register contents from peripherals
    input  wire [3:0]  sfr_ro_data,
    // rom addressing for calls and pattern fetch
    input  wire        rom_req,
    input  wire [1:0]  rom_kind,
    input  wire [13:0] rom_operand,
    output reg  [13:0] rom_addr_q,
    // interrupt handshake
    input  wire        irq_ack,
    output reg         irq_req_q,
    output reg  [13:0] vector_addr_q,
    output reg         sp_reset_q,
    // event sources
    input  wire [4:0]  ext_int_pin,
    input  wire [5:0]  internal_evt,
    input  wire        capture_done,
    input  wire        capture_overrun,
    input  wire        adc_done,
    // power modes
    input  wire        stop_enter,
    input  wire        stop_clear_input,
    input  wire        subactive_mode,
    output reg         stop_mode_q,
    // flag outputs
    output reg  [4:0]  power_flags_q,
    output reg  [3:0]  display_control_reg_q
);

    localparam [1:0] ST_ACTIVE = 2'b01;
    localparam [1:0] ST_STOP   = 2'b10;
    reg [31:0] ctl_q, ctl_d;
    reg [3:0]  sfr_q [0:63];
    reg [3:0]  ram [0:`RMCB_RAM_DEPTH-1];
    reg [1:0]  state_q;
    reg [4:0]  ext_s1_q, ext_s2_q, ext_prev_q;
    reg        stop_clear_input_s1_q, stop_clear_input_s2_q;
    reg [31:0] hw_set, hw_clr, bit_set, bit_clr;
    reg [10:0] pend;
    reg [13:0] vec_sel;
    reg        any_pend, found;
    // one loop index per process keeps every variable single-driven
    integer    s, k, j, m;

    wire [4:0]  ext_act   = ext_s2_q ^ `RMCB_EXT_ACT_LOW;
    wire [4:0]  ext_prv   = ext_prev_q ^ `RMCB_EXT_ACT_LOW;
    wire [4:0]  ext_evt   = ext_act & ~ext_prv;
    wire [10:0] src_evt   = {internal_evt[5], ext_evt[4:2], internal_evt[4:0], ext_evt[1:0]};
    wire        in_ctl_lo = (op_addr <= `RMCB_INTR_CTRL_TIMER_D_ADC);
    wire        in_ctl_hi = (op_addr >= `RMCB_FLAG_POWER_WATCHDOG_ADC) &&
                            (op_addr <= `RMCB_INTR_CTRL_EXT4_SERIAL);
    wire        in_ctl    = in_ctl_lo || in_ctl_hi;
    wire        in_sfr    = ((op_addr >= `RMCB_SFR_LO_FIRST) && (op_addr <= `RMCB_SFR_LO_LAST)) ||
                            ((op_addr >= `RMCB_SFR_HI_FIRST) && (op_addr <= `RMCB_SFR_HI_LAST));
    wire        in_ram    = (op_addr >= `RMCB_RAM_BASE) && (op_addr < `RMCB_RAM_END);
    wire [10:0] ram_off   = op_addr - `RMCB_RAM_BASE;
    wire [5:0]  sfr_idx   = op_addr[5:0];
    wire [4:0]  ctl_pos   = {in_ctl_hi, op_addr[1:0], op_bit};
    wire        sfr_ro    = |(`RMCB_SFR_RO_MASK & (64'h0000_0000_0000_0001 << sfr_idx));
    wire        sfr_wo    = |(`RMCB_SFR_WO_MASK & (64'h0000_0000_0000_0001 << sfr_idx));
    wire        is_bitop  = (op_kind == `RMCB_OP_SET) || (op_kind == `RMCB_OP_CLEAR);
    wire        stop_exit = state_q[1] && stop_clear_input_s2_q;

    // hardware events, permissions and pending sources
    always @* begin
        hw_set   = 32'h0000_0000;
        hw_clr   = 32'h0000_0000;
        bit_set  = 32'h0000_0000;
        bit_clr  = 32'h0000_0000;
        pend     = 11'h000;
        vec_sel  = `RMCB_RESET_VECTOR;
        found    = 1'b0;
        for (s = 0; s < `RMCB_NUM_SRC; s = s + 1) begin
            k = (s < 7) ? (2 + 2 * s) : (24 + 2 * (s - 7));
            // RULE_09: request flag per source
            hw_set[k] = src_evt[s];
            pend[s]   = ctl_q[k] & ~ctl_q[k + 1];
            if (pend[s] && !found) begin
                found = 1'b1;
                // RULE_01: vector within first words
                case (s)
                    0:       vec_sel = 14'h0002;
                    1:       vec_sel = 14'h0004;
                    2:       vec_sel = 14'h0006;
                    3:       vec_sel = 14'h0008;
                    4:       vec_sel = 14'h000A;
                    5, 6:    vec_sel = 14'h000C;
                    default: vec_sel = 14'h000E;
                endcase
            end
        end
        hw_set[`RMCB_POS_CAPTURE_STATUS] = capture_done;
        hw_set[`RMCB_POS_CAPTURE_ERROR]  = capture_overrun;
        hw_clr[`RMCB_POS_ADC_START]      = adc_done;
        // RULE_13: stop clear drops watchdog
        hw_clr[`RMCB_POS_WATCHDOG_ON]    = stop_exit;
        // direct transfer never holds in active mode
        hw_clr[`RMCB_POS_DIRECT_XFER_ON] = ~subactive_mode;
        // RULE_05: bit instructions only, per-bit limits
        // RULE_08: flag area same access limits
        if (op_valid && in_ctl) begin
            bit_set[ctl_pos] = (op_kind == `RMCB_OP_SET);
            bit_clr[ctl_pos] = (op_kind == `RMCB_OP_CLEAR);
        end
        bit_set = bit_set & `RMCB_SET_OK;
        bit_clr = bit_clr & `RMCB_CLR_OK;
        bit_set[`RMCB_POS_DIRECT_XFER_ON] = bit_set[`RMCB_POS_DIRECT_XFER_ON] & subactive_mode;
        any_pend = ctl_q[`RMCB_POS_GLOBAL_IRQ_ENABLE] & (|pend);
    end

    // hardware set beats any clear in the same cycle
    always @* begin
        ctl_d = ctl_q;
        for (j = 0; j < 32; j = j + 1) begin
            if (hw_set[j] || bit_set[j])
                ctl_d[j] = 1'b1;
            else if (hw_clr[j] || bit_clr[j])
                ctl_d[j] = 1'b0;
        end
        // RULE_15: unused and stateless positions stay zero
        ctl_d[22] = 1'b0;
        // RULE_10: sp reset bit holds no state, clear acts
        ctl_d[`RMCB_POS_SP_RESET] = 1'b0;
        // accepted interrupt drops the global enable
        if (irq_ack && any_pend)
            ctl_d[`RMCB_POS_GLOBAL_IRQ_ENABLE] = 1'b0;
    end

    // pin synchronisers
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_s1_q   <= 5'h00;
            ext_s2_q   <= 5'h00;
            ext_prev_q <= 5'h00;
            stop_clear_input_s1_q <= 1'b0;
            stop_clear_input_s2_q <= 1'b0;
        end else begin
            ext_s1_q   <= ext_int_pin;
            ext_s2_q   <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
            stop_clear_input_s1_q <= stop_clear_input;
            stop_clear_input_s2_q <= stop_clear_input_s1_q;
        end
    end

    // stop mode state
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q     <= ST_ACTIVE;
            stop_mode_q <= 1'b0;
        end else begin
            case (state_q)
                ST_ACTIVE: begin
                    if (stop_enter) begin
                        state_q     <= ST_STOP;
                        stop_mode_q <= 1'b1;
                    end
                end
                ST_STOP: begin
                    // RULE_12: stop clear wakes to active
                    if (stop_clear_input_s2_q) begin
                        state_q     <= ST_ACTIVE;
                        stop_mode_q <= 1'b0;
                    end
                end
                default: begin
                    state_q     <= ST_ACTIVE;
                    stop_mode_q <= 1'b0;
                end
            endcase
        end
    end

    // control bits, interrupt outputs and rom addressing
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // RULE_16: masked and disabled from reset
            ctl_q         <= `RMCB_CTL_RESET;
            irq_req_q     <= 1'b0;
            vector_addr_q <= `RMCB_RESET_VECTOR;
            sp_reset_q    <= 1'b0;
            rom_addr_q    <= 14'h0000;
            power_flags_q <= 5'h00;
        end else begin
            ctl_q      <= ctl_d;
            irq_req_q  <= ctl_d[`RMCB_POS_GLOBAL_IRQ_ENABLE] & any_pend & ~irq_ack;
            sp_reset_q <= op_valid && in_ctl && (op_kind == `RMCB_OP_CLEAR) &&
                          (ctl_pos == `RMCB_POS_SP_RESET);
            if (irq_ack && any_pend)
                vector_addr_q <= vec_sel & `RMCB_VECTOR_LAST;
            if (rom_req) begin
                // RULE_02: call target forced into zero page
                if (rom_kind == `RMCB_ROM_CAL)
                    rom_addr_q <= rom_operand & `RMCB_ZPAGE_MASK;
                // RULE_03: pattern reads limited to pattern area
                else if (rom_kind == `RMCB_ROM_PATTERN)
                    rom_addr_q <= rom_operand & `RMCB_PATTERN_MASK;
                else
                    rom_addr_q <= rom_operand;
            end
            // RULE_11: low speed, watchdog, adc start, direct transfer, ram enable
            power_flags_q <= {ctl_d[`RMCB_POS_RAM_ENABLE], ctl_d[`RMCB_POS_DIRECT_XFER_ON],
                              ctl_d[`RMCB_POS_ADC_START], ctl_d[`RMCB_POS_WATCHDOG_ON],
                              ctl_d[`RMCB_POS_LOW_SPEED_ON]};
        end
    end

    // special function registers
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (m = 0; m < 64; m = m + 1)
                sfr_q[m] <= 4'h0;
            display_control_reg_q <= 4'h0;
        end else begin
            // RULE_06: read-only entries ignore writes
            if (op_valid && in_sfr && !sfr_ro && (op_kind == `RMCB_OP_WRITE))
                sfr_q[sfr_idx] <= op_wdata;
            // RULE_07: bit set/clear honoured only here
            if (op_valid && is_bitop && (op_addr == `RMCB_DISP_CTRL)) begin
                sfr_q[sfr_idx][op_bit] <= (op_kind == `RMCB_OP_SET);
                display_control_reg_q[op_bit] <= (op_kind == `RMCB_OP_SET);
            end else if (op_valid && (op_addr == `RMCB_DISP_CTRL) && (op_kind == `RMCB_OP_WRITE)) begin
                display_control_reg_q <= op_wdata;
            end
        end
    end

    // RULE_04: ordinary ram above the register area, no reset
    always @(posedge core_clk) begin
        if (op_valid && in_ram && (op_kind == `RMCB_OP_WRITE))
            ram[ram_off] <= op_wdata;
    end

    // read data and test result, one cycle after the request
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q     <= 4'h0;
            rd_valid_q    <= 1'b0;
            status_flag_q <= 1'b0;
        end else begin
            rd_valid_q <= op_valid && ((op_kind == `RMCB_OP_READ) || (op_kind == `RMCB_OP_TEST));
            if (op_valid && (op_kind == `RMCB_OP_READ)) begin
                // control areas give nothing to nibble reads
                if (in_ram)
                    rd_data_q <= ram[ram_off];
                else if (in_sfr && sfr_ro)
                    rd_data_q <= sfr_ro_data;
                else if (in_sfr && !sfr_wo)
                    rd_data_q <= sfr_q[sfr_idx];
                else
                    rd_data_q <= 4'h0;
            end
            if (op_valid && (op_kind == `RMCB_OP_TEST)) begin
                // RULE_14: inhibited or absent bits test as zero
                if (in_ctl)
                    status_flag_q <= ctl_q[ctl_pos] & (|(`RMCB_TST_OK & (32'h0000_0001 << ctl_pos)));
                else if (in_ram)
                    status_flag_q <= ram[ram_off][op_bit];
                else
                    status_flag_q <= 1'b0;
            end
        end
    end

endmodule

/* test/rmcb_bank_sva.sv */
// port assertions for the control bit bank
`timescale 1ns/100ps
`include "rmcb_defs.vh"
module rmcb_bank_sva (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // core data access
    input wire logic        op_valid,
    input wire logic [2:0]  op_kind,
    input wire logic [10:0] op_addr,
    input wire logic [1:0]  op_bit,
    input wire logic [3:0]  rd_data_q,
    input wire logic        rd_valid_q,
    // rom and interrupt
    input wire logic        rom_req,
    input wire logic [1:0]  rom_kind,
    input wire logic [13:0] rom_operand,
    input wire logic [13:0] rom_addr_q,
    input wire logic        irq_ack,
    input wire logic        irq_req_q,
    input wire logic [13:0] vector_addr_q,
    input wire logic        sp_reset_q,
    // power and flags
    input wire logic        stop_clear_input,
    input wire logic        subactive_mode,
    input wire logic        stop_mode_q,
    input wire logic [4:0]  power_flags_q,
    input wire logic [3:0]  display_control_reg_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire ctl_area = (op_addr[10:2] == 9'h000) || (op_addr[10:2] == 9'h008);
    sequence s_rd_req; op_valid && (op_kind == `RMCB_OP_READ || op_kind == `RMCB_OP_TEST); endsequence
    sequence s_sp_clr; op_valid && op_kind == `RMCB_OP_CLEAR && op_addr == 11'h0000 && op_bit == 2'h1; endsequence
    sequence s_sp_pulse; sp_reset_q ##1 !sp_reset_q; endsequence
    chk_read_answer: assert property (s_rd_req |=> rd_valid_q)
        else $error("read answer missing");
    chk_ctl_nibble_zero: assert property (op_valid && op_kind == `RMCB_OP_READ && ctl_area |=> rd_data_q == 4'h0)
        else $error("control nibble read not zero");
    chk_call_zero_page: assert property (rom_req && rom_kind == `RMCB_ROM_CAL |=>
        rom_addr_q == ($past(rom_operand) & `RMCB_ZPAGE_MASK))
        else $error("call left zero page");
    chk_pattern_area: assert property (rom_req && rom_kind == `RMCB_ROM_PATTERN |=>
        rom_addr_q == ($past(rom_operand) & `RMCB_PATTERN_MASK))
        else $error("pattern address out of area");
    chk_vector_range: assert property (irq_ack && irq_req_q |=> !irq_req_q && vector_addr_q <= `RMCB_VECTOR_LAST)
        else $error("vector outside vector area");
    chk_sp_reset_pulse: assert property (s_sp_clr |=> s_sp_pulse)
        else $error("stack reset pulse wrong");
    chk_lcd_bit_set: assert property (op_valid && op_kind == `RMCB_OP_SET && op_addr == `RMCB_DISP_CTRL &&
        op_bit != 2'h3 |=> display_control_reg_q[$past(op_bit)])
        else $error("display control bit not set");
    chk_stop_exit: assert property ($rose(stop_clear_input) && stop_mode_q |->
        ##[1:4] (!stop_mode_q && !power_flags_q[1]))
        else $error("stop clear did not leave stop");
    chk_wdog_clear_kept: assert property (op_valid && op_kind == `RMCB_OP_CLEAR && op_addr == 11'h0020 &&
        op_bit == 2'h1 && !stop_clear_input |=> $stable(power_flags_q[1]))
        else $error("watchdog flag cleared by software");
    chk_dxfer_active: assert property (!subactive_mode |=> !power_flags_q[3])
        else $error("direct transfer set in active mode");
endmodule
bind rmcb_bank rmcb_bank_sva u_sva (.core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid), .op_kind(op_kind),
    .op_addr(op_addr), .op_bit(op_bit), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .rom_req(rom_req),
    .rom_kind(rom_kind), .rom_operand(rom_operand), .rom_addr_q(rom_addr_q), .irq_ack(irq_ack),
    .irq_req_q(irq_req_q), .vector_addr_q(vector_addr_q), .sp_reset_q(sp_reset_q),
    .stop_clear_input(stop_clear_input), .subactive_mode(subactive_mode), .stop_mode_q(stop_mode_q),
    .power_flags_q(power_flags_q), .display_control_reg_q(display_control_reg_q));

/* test/rmcb_core_model.sv */
// core-side model that accepts interrupts after a chosen delay
`timescale 1ns/100ps
module rmcb_core_model (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_b,
    // interrupt handshake
    input wire logic       irq_req_q,
    input wire logic [3:0] ack_delay,
    output logic           irq_ack
);
    logic [3:0] wait_q;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ack <= 1'b0;
            wait_q  <= 4'h0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            wait_q  <= 4'h0;
        end else if (irq_req_q) begin
            // a slow core leaves the request standing for several cycles
            irq_ack <= (wait_q == ack_delay);
            wait_q  <= wait_q + 4'h1;
        end else begin
            wait_q <= 4'h0;
        end
    end
endmodule

/* test/rmcb_bank_tb_top.sv */
// self-checking bench for the control bit bank
`timescale 1ns/100ps
`include "rmcb_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module rmcb_bank_tb_top;
    reg         core_clk, rst_b, op_valid, rom_req, stop_enter, stop_clear_input, subactive_mode, adc_done;
    reg  [2:0]  op_kind;
    reg  [10:0] op_addr, a;
    reg  [1:0]  op_bit, rom_kind;
    reg  [3:0]  op_wdata, sfr_ro_data, ack_delay, d;
    reg  [13:0] rom_operand;
    reg  [5:0]  internal_evt;
    reg  [4:0]  ext_int_pin;
    reg         capture_done, capture_overrun;
    wire [3:0]  rd_data_q, display_control_reg_q;
    wire        rd_valid_q, status_flag_q, irq_req_q, sp_reset_q, stop_mode_q, irq_ack;
    wire [13:0] rom_addr_q, vector_addr_q;
    wire [4:0]  power_flags_q;
    integer     seed, err_total, checked, i, n;
    // mask place of each internal source: {addr, bit}
    reg  [12:0] msk [0:5];
    rmcb_bank DUT (.core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr),
        .op_bit(op_bit), .op_wdata(op_wdata), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .status_flag_q(status_flag_q), .sfr_ro_data(sfr_ro_data), .rom_req(rom_req), .rom_kind(rom_kind),
        .rom_operand(rom_operand), .rom_addr_q(rom_addr_q), .irq_ack(irq_ack), .irq_req_q(irq_req_q),
        .vector_addr_q(vector_addr_q), .sp_reset_q(sp_reset_q), .ext_int_pin(ext_int_pin),
        .internal_evt(internal_evt), .capture_done(capture_done), .capture_overrun(capture_overrun),
        .adc_done(adc_done),
        .stop_enter(stop_enter), .stop_clear_input(stop_clear_input), .subactive_mode(subactive_mode),
        .stop_mode_q(stop_mode_q), .power_flags_q(power_flags_q), .display_control_reg_q(display_control_reg_q));
    rmcb_core_model u_core (.core_clk(core_clk), .rst_b(rst_b), .irq_req_q(irq_req_q), .ack_delay(ack_delay),
        .irq_ack(irq_ack));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    function [13:0] rom_exp(input [1:0] k, input [13:0] o);
        rom_exp = (k == `RMCB_ROM_CAL) ? (o & `RMCB_ZPAGE_MASK) : (o & `RMCB_PATTERN_MASK);
    endfunction
    function [13:0] vec_exp(input integer s);
        vec_exp = (s < 4) ? 14'h0006 + 14'h0002 * s[13:0] : ((s == 4) ? 14'h000C : 14'h000E);
    endfunction
    task test_done;
        begin
            $display("checks %0d errors %0d", checked, err_total);
            if (err_total == 0 && checked > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    // one request, taken at the second edge, answer sampled mid-cycle
    task op(input [2:0] k, input [10:0] ad, input [1:0] b, input [3:0] w);
        begin
            @(posedge core_clk);
            op_valid <= 1'b1; op_kind <= k; op_addr <= ad; op_bit <= b; op_wdata <= w;
            @(posedge core_clk);
            op_valid <= 1'b0;
            @(negedge core_clk);
        end
    endtask
    task cycles(input integer c);
        repeat (c) @(negedge core_clk);
    endtask
    // bounded wait for the core to accept, then one edge for the vector
    task wait_ack;
        begin
            n = 0;
            while (irq_ack !== 1'b1 && n < 60) begin cycles(1); n++; end
            if (n >= 60) begin err_total++; test_done; end
            cycles(1);
        end
    endtask
    initial begin
        seed = 56590; err_total = 0; checked = 0; rst_b = 1'b0; op_valid = 1'b0; op_kind = 3'h0;
        op_addr = 11'h0000; op_bit = 2'h0; op_wdata = 4'h0; sfr_ro_data = 4'h0; rom_req = 1'b0; rom_kind = 2'h0;
        rom_operand = 14'h0000; internal_evt = 6'h00; ext_int_pin = 5'h03; adc_done = 1'b0; stop_enter = 1'b0;
        stop_clear_input = 1'b0; subactive_mode = 1'b0; ack_delay = 4'h0;
        capture_done = 1'b0; capture_overrun = 1'b0;
        msk[0] = {11'h001, 2'h3}; msk[1] = {11'h002, 2'h1}; msk[2] = {11'h002, 2'h3};
        msk[3] = {11'h003, 2'h1}; msk[4] = {11'h003, 2'h3}; msk[5] = {11'h023, 2'h3};
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        `CHK(power_flags_q, 5'h00)
        `CHK({irq_req_q, vector_addr_q}, 15'h0000)
        op(`RMCB_OP_TEST, 11'h000, 2'h3, 4'h0); `CHK(status_flag_q, 1'b1)
        op(`RMCB_OP_TEST, 11'h000, 2'h0, 4'h0); `CHK(status_flag_q, 1'b0)
        // data ram, both ends and random places
        for (i = 0; i < 24; i++) begin
            a = (i == 0) ? 11'h040 : ((i == 1) ? 11'h793 : 11'h040 + {$random(seed)} % 1876);
            d = $random(seed);
            op(`RMCB_OP_WRITE, a, 2'h0, d);
            op(`RMCB_OP_READ, a, 2'h0, 4'h0);
            `CHK({rd_valid_q, rd_data_q}, {1'b1, d})
        end
        op(`RMCB_OP_READ, 11'h794, 2'h0, 4'h0); `CHK(rd_data_q, 4'h0)
        for (i = 0; i < 8; i++) begin
            a = {5'h00, i[2], 3'h0, i[1:0]};
            op(`RMCB_OP_WRITE, a, 2'h0, 4'hF);
            op(`RMCB_OP_READ, a, 2'h0, 4'h0); `CHK(rd_data_q, 4'h0)
        end
        op(`RMCB_OP_TEST, 11'h000, 2'h0, 4'h0); `CHK(status_flag_q, 1'b0)
        op(`RMCB_OP_TEST, 11'h000, 2'h1, 4'h0); `CHK(status_flag_q, 1'b0)
        op(`RMCB_OP_SET, 11'h021, 2'h2, 4'h0);
        op(`RMCB_OP_TEST, 11'h021, 2'h2, 4'h0); `CHK(status_flag_q, 1'b0)
        op(`RMCB_OP_SET, 11'h021, 2'h3, 4'h0);
        op(`RMCB_OP_TEST, 11'h021, 2'h3, 4'h0); `CHK(status_flag_q, 1'b0)
        op(`RMCB_OP_SET, 11'h020, 2'h0, 4'h0); `CHK(power_flags_q[0], 1'b1)
        op(`RMCB_OP_SET, 11'h020, 2'h1, 4'h0);
        op(`RMCB_OP_CLEAR, 11'h020, 2'h1, 4'h0); `CHK(power_flags_q[1], 1'b1)
        op(`RMCB_OP_SET, 11'h020, 2'h2, 4'h0); `CHK(power_flags_q[2], 1'b1)
        @(posedge core_clk); adc_done <= 1'b1;
        @(posedge core_clk); adc_done <= 1'b0; cycles(2); `CHK(power_flags_q[2], 1'b0)
        op(`RMCB_OP_SET, 11'h020, 2'h3, 4'h0); `CHK(power_flags_q[3], 1'b0)
        @(posedge core_clk); subactive_mode <= 1'b1;
        op(`RMCB_OP_SET, 11'h020, 2'h3, 4'h0); `CHK(power_flags_q[3], 1'b1)
        @(posedge core_clk); subactive_mode <= 1'b0;
        op(`RMCB_OP_CLEAR, 11'h000, 2'h1, 4'h0); `CHK(sp_reset_q, 1'b1)
        // special function window
        for (i = 0; i < 3; i++) op(`RMCB_OP_SET, `RMCB_DISP_CTRL, i[1:0], 4'h0);
        op(`RMCB_OP_CLEAR, `RMCB_DISP_CTRL, 2'h1, 4'h0); `CHK(display_control_reg_q[2:0], 3'h5)
        op(`RMCB_OP_WRITE, 11'h01C, 2'h0, 4'h5);
        op(`RMCB_OP_SET, 11'h01C, 2'h1, 4'h0);
        op(`RMCB_OP_READ, 11'h01C, 2'h0, 4'h0); `CHK(rd_data_q, 4'h5)
        @(posedge core_clk); sfr_ro_data <= $random(seed);
        op(`RMCB_OP_READ, 11'h017, 2'h0, 4'h0); `CHK(rd_data_q, sfr_ro_data)
        op(`RMCB_OP_WRITE, 11'h008, 2'h0, 4'hA);
        op(`RMCB_OP_READ, 11'h008, 2'h0, 4'h0); `CHK(rd_data_q, 4'h0)
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            rom_req <= 1'b1; rom_kind <= i[0] ? `RMCB_ROM_CAL : `RMCB_ROM_PATTERN; rom_operand <= $random(seed);
            @(posedge core_clk);
            rom_req <= 1'b0;
            @(negedge core_clk); `CHK(rom_addr_q, rom_exp(rom_kind, rom_operand))
        end
        // each internal source, alternating prompt and slow acceptance
        for (i = 0; i < 6; i++) begin
            @(posedge core_clk); ack_delay <= i[0] ? 4'h5 : 4'h0;
            op(`RMCB_OP_CLEAR, msk[i][12:2], msk[i][1:0], 4'h0);
            @(posedge core_clk); internal_evt <= 6'h01 << i; @(posedge core_clk); internal_evt <= 6'h00;
            cycles(4); `CHK(irq_req_q, 1'b0)
            op(`RMCB_OP_SET, 11'h000, 2'h0, 4'h0);
            wait_ack; `CHK(vector_addr_q, vec_exp(i))
            op(`RMCB_OP_TEST, 11'h000, 2'h0, 4'h0); `CHK(status_flag_q, 1'b0)
            op(`RMCB_OP_SET, msk[i][12:2], msk[i][1:0], 4'h0);
        end
        // external pin 0 idles high, so a falling level is its event
        @(posedge core_clk); ext_int_pin <= 5'h02;
        cycles(5);
        op(`RMCB_OP_TEST, 11'h000, 2'h2, 4'h0); `CHK(status_flag_q, 1'b1)
        op(`RMCB_OP_CLEAR, 11'h000, 2'h3, 4'h0);
        op(`RMCB_OP_SET, 11'h000, 2'h0, 4'h0);
        wait_ack; `CHK(vector_addr_q, 14'h0002)
        @(posedge core_clk); capture_done <= 1'b1; capture_overrun <= 1'b1;
        @(posedge core_clk); capture_done <= 1'b0; capture_overrun <= 1'b0;
        op(`RMCB_OP_TEST, 11'h021, 2'h0, 4'h0); `CHK(status_flag_q, 1'b1)
        op(`RMCB_OP_CLEAR, 11'h021, 2'h1, 4'h0);
        op(`RMCB_OP_TEST, 11'h021, 2'h1, 4'h0); `CHK(status_flag_q, 1'b0)
        op(`RMCB_OP_SET, 11'h020, 2'h1, 4'h0);
        @(posedge core_clk); stop_enter <= 1'b1; @(posedge core_clk); stop_enter <= 1'b0;
        cycles(1); `CHK(stop_mode_q, 1'b1)
        @(posedge core_clk); stop_clear_input <= 1'b1;
        cycles(6); `CHK({stop_mode_q, power_flags_q[1]}, 2'b00)
        stop_clear_input <= 1'b0;
        cycles(2);
        test_done;
    end
endmodule
